// *** dv/prc_chk.sv ***
`timescale 1ns/1ns

module prc_chk import prc_pkg::*; (
   input wire logic     core_clk,
   input wire logic     rst_b,
   input wire logic     ce,
   input wire prc_cmd_s cmd,
   input wire logic     cmd_valid,
   input wire logic     cmd_ready,
   input wire prc_mem_s mem,
   input wire logic     mem_ack,
   input wire prc_rsp_s rsp,
   input wire logic     rsp_valid,
   input wire logic     rsp_ready,
   input wire logic     pwr_ok_pin,
   input wire logic     link_run,
   input wire logic     plc_run,
   input wire logic     remote_forced
);
   logic [2:0] up_r;
   logic [2:0] up_nxt;
   logic       take;

   // power must be seen good through the synchroniser before forcing sticks
   always_comb up_nxt = (!pwr_ok_pin || !ce) ? 3'h0 : ((up_r == 3'h7) ? up_r : up_r + 3'h1);
   always_comb take = cmd_valid && cmd_ready && ce;
   always_ff @(posedge core_clk) begin
      if (!rst_b) up_r <= 3'h0;
      else up_r <= up_nxt;
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   remote_run_a:
      assert property (take && cmd.code == 8'h13 && up_r >= 3'h4 |=> remote_forced && plc_run)
      else $error("remote run not applied");
   remote_stop_a:
      assert property (take && cmd.code == 8'h14 && up_r >= 3'h4 |=> remote_forced && !plc_run)
      else $error("remote stop not applied");
   link_order_a:
      assert property (ce && link_run && !take && up_r >= 3'h4 |=> remote_forced && plc_run)
      else $error("link run not applied");
   power_clear_a:
      assert property ((!pwr_ok_pin && ce) [*3] |=> ##[0:1] !remote_forced)
      else $error("forcing kept after power loss");
   odd_count_a:
      assert property (take && cmd.c32 && (((cmd.code == 8'h01 || cmd.code == 8'h03) && cmd.points[0])
         || cmd.code == 8'h05) |=> rsp_valid && rsp.last && !mem.req && rsp.data == {$past(cmd.code), 8'h57})
      else $error("odd counter count not refused");
   rsp_hold_a:
      assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp))
      else $error("response dropped before accept");
   mem_hold_a:
      assert property (mem.req && !mem_ack |=> mem.req && $stable(mem))
      else $error("memory request changed before ack");
   mem_release_a:
      assert property (mem.req && mem_ack |=> !mem.req)
      else $error("memory request held after ack");
   cmd_busy_a:
      assert property (take |=> !cmd_ready)
      else $error("command taken while busy");
endmodule

bind prc_cmd_handler prc_chk u_chk (
   .core_clk     (core_clk),
   .rst_b        (rst_b),
   .ce           (ce),
   .cmd          (cmd),
   .cmd_valid    (cmd_valid),
   .cmd_ready    (cmd_ready),
   .mem          (mem),
   .mem_ack      (mem_ack),
   .rsp          (rsp),
   .rsp_valid    (rsp_valid),
   .rsp_ready    (rsp_ready),
   .pwr_ok_pin   (pwr_ok_pin),
   .link_run     (link_run),
   .plc_run      (plc_run),
   .remote_forced(remote_forced)
);

// *** dv/prc_cmd_handler_test.sv ***
`timescale 1ns/1ns

module prc_cmd_handler_test import prc_pkg::*;;
   localparam logic [7:0] MODEL = 8'hA5; // arbitrary value
   logic        core_clk, rst_b, ce, cmd_valid, cmd_ready, din_valid, din_ready, mem_ack;
   logic        rsp_valid, rsp_ready, run_switch_pin, pwr_ok_pin, link_run, link_stop;
   logic        plc_run, remote_forced;
   prc_cmd_s    cmd;
   prc_din_s    din;
   prc_mem_s    mem;
   prc_rsp_s    rsp;
   logic [15:0] mem_rdata;
   int          failures, cmp_count, wd;

   prc_cmd_handler #(.MODEL_CODE(MODEL)) uut (.core_clk(core_clk), .rst_b(rst_b), .ce(ce), .cmd(cmd),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .din(din), .din_valid(din_valid), .din_ready(din_ready),
      .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .rsp(rsp), .rsp_valid(rsp_valid),
      .rsp_ready(rsp_ready), .run_switch_pin(run_switch_pin), .pwr_ok_pin(pwr_ok_pin), .link_run(link_run),
      .link_stop(link_stop), .plc_run(plc_run), .remote_forced(remote_forced));
   prc_mem_model u_mem (.core_clk(core_clk), .rst_b(rst_b), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic send_cmd(input logic [7:0] code, input logic c32, input logic [15:0] head, input logic [7:0] pts);
      cmd <= '{code, c32, head, pts};
      cmd_valid <= 1'b1;
      do @(posedge core_clk); while (!cmd_ready);
      cmd_valid <= 1'b0;
   endtask

   // data is judged while ready is still low, so every beat also stalls once
   task automatic get_beat(input logic [15:0] exp, input logic last);
      do @(posedge core_clk); while (!rsp_valid);
      check("rsp.data", rsp.data, exp);
      check("rsp.last", 16'(rsp.last), 16'(last));
      rsp_ready <= 1'b1;
      @(posedge core_clk);
      rsp_ready <= 1'b0;
   endtask

   task automatic send_din(input logic [15:0] a, input logic [15:0] d);
      din <= '{a, d};
      din_valid <= 1'b1;
      do @(posedge core_clk); while (!din_ready);
      din_valid <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic t_wr_rd;
      send_cmd(8'h03, 1'b0, 16'h0010, 8'h03);
      for (int i = 0; i < 3; i++) send_din(16'h0000, 16'hC3C0 + 16'(i));
      get_beat(16'h0300, 1'b1);
      send_cmd(8'h01, 1'b0, 16'h000F, 8'h05);
      get_beat(16'h0100, 1'b0);
      // neighbours on both sides of the written range stay untouched
      for (int i = 0; i < 5; i++)
         get_beat((i == 0 || i == 4) ? {8'h5A, 8'(15 + i)} : 16'hC3C0 + 16'(i - 1), i == 4);
   endtask

   task automatic t_rand_wr;
      send_cmd(8'h05, 1'b0, 16'h0000, 8'h02);
      send_din(16'h0031, 16'h0B0B);
      send_din(16'h0030, 16'h0A0A);
      get_beat(16'h0500, 1'b1);
      send_cmd(8'h01, 1'b0, 16'h0030, 8'h02);
      get_beat(16'h0100, 1'b0);
      get_beat(16'h0A0A, 1'b0);
      get_beat(16'h0B0B, 1'b1);
   endtask

   task automatic t_errors;
      logic [7:0] cd [4] = '{8'h01, 8'h03, 8'h05, 8'h02};
      logic [7:0] pt [4] = '{8'h03, 8'h01, 8'h02, 8'h01};
      for (int i = 0; i < 4; i++) begin
         send_cmd(cd[i], i < 3, 16'h00C8, pt[i]);
         get_beat({cd[i], (i < 3) ? 8'h57 : 8'h50}, 1'b1);
      end
      send_cmd(8'h01, 1'b1, 16'h00C8, 8'h02);
      get_beat(16'h0100, 1'b0);
      get_beat(16'h5AC8, 1'b0);
      get_beat(16'h5AC9, 1'b1);
      send_cmd(8'h03, 1'b1, 16'h00C8, 8'h02);
      send_din(16'h0000, 16'h5678);
      send_din(16'h0000, 16'h1234);
      get_beat(16'h0300, 1'b1);
      send_cmd(8'h01, 1'b1, 16'h00C8, 8'h02);
      get_beat(16'h0100, 1'b0);
      get_beat(16'h5678, 1'b0);
      get_beat(16'h1234, 1'b1);
   endtask

   task automatic t_run_stop;
      run_switch_pin <= 1'b0;
      send_cmd(8'h13, 1'b0, 16'h0000, 8'h00);
      get_beat(16'h1300, 1'b1);
      check("plc_run", 16'(plc_run), 16'h0001);
      run_switch_pin <= 1'b1;
      send_cmd(8'h14, 1'b0, 16'h0000, 8'h00);
      get_beat(16'h1400, 1'b1);
      check("plc_run", 16'(plc_run), 16'h0000);
      link_run <= 1'b1;
      @(posedge core_clk);
      link_run <= 1'b0;
      repeat (2) @(posedge core_clk);
      check("plc_run", 16'(plc_run), 16'h0001);
      link_stop <= 1'b1;
      @(posedge core_clk);
      link_stop <= 1'b0;
      repeat (2) @(posedge core_clk);
      check("plc_run", 16'(plc_run), 16'h0000);
      // a link run while the clock enable is low is lost
      ce <= 1'b0;
      link_run <= 1'b1;
      @(posedge core_clk);
      link_run <= 1'b0;
      ce <= 1'b1;
      repeat (4) @(posedge core_clk);
      check("plc_run", 16'(plc_run), 16'h0000);
      // own stop lands in the same cycle as a link run and must win
      run_switch_pin <= 1'b1;
      link_run <= 1'b1;
      send_cmd(8'h14, 1'b0, 16'h0000, 8'h00);
      link_run <= 1'b0;
      get_beat(16'h1400, 1'b1);
      check("plc_run", 16'(plc_run), 16'h0000);
      pwr_ok_pin <= 1'b0;
      repeat (4) @(posedge core_clk);
      pwr_ok_pin <= 1'b1;
      repeat (5) @(posedge core_clk);
      check("remote_forced", 16'(remote_forced), 16'h0000);
      check("plc_run", 16'(plc_run), 16'h0001);
   endtask

   task automatic t_model_loop;
      logic [7:0] b [8] = '{8'h00, 8'hFF, 8'h3C, 8'h81, 8'h30, 8'h39, 8'h41, 8'h46};
      send_cmd(8'h15, 1'b0, 16'h0000, 8'h00);
      get_beat(16'h1500, 1'b0);
      // model judged by code beat only
      get_beat({8'h00, MODEL}, 1'b1);
      // binary bytes, then hex digit characters
      for (int k = 0; k < 8; k += 4) begin
         send_cmd(8'h16, 1'b0, 16'h0000, 8'h04);
         din_valid <= 1'b1;
         for (int i = 0; i < 4; i++) begin
            din <= '{16'h0000, {8'h00, b[k+i]}};
            do @(posedge core_clk); while (!din_ready);
         end
         din_valid <= 1'b0;
         get_beat(16'h1600, 1'b0);
         for (int i = 0; i < 4; i++) get_beat({8'h00, b[k+i]}, i == 3);
      end
      send_cmd(8'h16, 1'b0, 16'h0000, 8'hFE);
      din_valid <= 1'b1;
      for (int i = 0; i < 254; i++) begin
         din <= '{16'h0000, {8'h00, 8'(8'hFF - i)}};
         do @(posedge core_clk); while (!din_ready);
      end
      din_valid <= 1'b0;
      get_beat(16'h1600, 1'b0);
      for (int i = 0; i < 254; i++) get_beat({8'h00, 8'(8'hFF - i)}, i == 253);
      send_cmd(8'h16, 1'b0, 16'h0000, 8'hFF);
      get_beat(16'h1651, 1'b1);
   endtask

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      wd++;
      if (wd == 5000) begin
         failures++;
         tally_and_finish();
      end
   end

   initial begin
      {rst_b, cmd_valid, din_valid, rsp_ready, run_switch_pin, link_run, link_stop} = '0;
      {failures, cmp_count, wd} = '0;
      ce = 1'b1;
      pwr_ok_pin = 1'b1;
      cmd = '0;
      din = '0;
      repeat (10) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge core_clk);
      t_wr_rd();
      t_rand_wr();
      t_errors();
      t_run_stop();
      t_model_loop();
      tally_and_finish();
   end
endmodule

// *** dv/prc_mem_model.sv ***
`timescale 1ns/1ns

module prc_mem_model import prc_pkg::*; (
   input  wire logic     core_clk,
   input  wire logic     rst_b,
   input  wire prc_mem_s mem,
   output logic          mem_ack,
   output logic [15:0]   mem_rdata
);
   logic [15:0] store [256];
   logic [1:0]  wait_r;
   logic        slow_r;

   initial begin
      for (int i = 0; i < 256; i++) store[i] = {8'h5A, 8'(i)};
   end

   // alternates one and three wait cycles so both fast and slow answers occur
   always @(posedge core_clk) begin
      mem_ack <= 1'b0;
      if (!rst_b) begin
         wait_r <= 2'h0;
         slow_r <= 1'b0;
         mem_rdata <= 16'h0000;
      end else if (mem.req && !mem_ack) begin
         if (wait_r == (slow_r ? 2'h3 : 2'h1)) begin
            mem_ack <= 1'b1;
            wait_r <= 2'h0;
            slow_r <= !slow_r;
            if (mem.we) store[mem.addr[7:0]] <= mem.wdata;
            else mem_rdata <= store[mem.addr[7:0]];
         end else wait_r <= wait_r + 2'h1;
      end
      // read data only holds in the ack cycle; scrambled otherwise
      if (rst_b && (!mem.req || mem_ack)) mem_rdata <= ~mem_rdata;
   end
endmodule

// *** pkg/prc_map.svh ***
`ifndef PRC_MAP_SVH
`define PRC_MAP_SVH

// command codes
`define PRC_CMD_BATCH_RD  8'h01
`define PRC_CMD_BATCH_WR  8'h03
`define PRC_CMD_RAND_WR   8'h05
`define PRC_CMD_RUN       8'h13
`define PRC_CMD_STOP      8'h14
`define PRC_CMD_MODEL     8'h15
`define PRC_CMD_LOOP      8'h16

// end codes carried in the response header
`define PRC_END_OK        8'h00
`define PRC_ERR_ODD_C32   8'h57

// loopback payload limit in bytes
`define PRC_LB_MAX        8'hFE

// response header layout: command in the high byte, end code in the low byte
`define PRC_HDR_CMD_MSB   15
`define PRC_HDR_CMD_LSB   8
`define PRC_HDR_END_MSB   7
`define PRC_HDR_END_LSB   0

// reset values
`define PRC_IDX_RST       9'h000
`define PRC_WORD_RST      16'h0000
`define PRC_SYNC_RST      1'b0

`endif

// *** pkg/prc_pkg.sv ***
package prc_pkg;

   // codes listed as one gray sequence through write, header, read and loopback states
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b000,
      ST_DIN   = 3'b001,
      ST_MEMWR = 3'b011,
      ST_HDR   = 3'b010,
      ST_MEMRD = 3'b110,
      ST_SEND  = 3'b111,
      ST_LBRX  = 3'b101,
      ST_LBTX  = 3'b100
   } prc_state_e;

   typedef struct packed {
      logic [7:0]  code;
      logic        c32;
      logic [15:0] head;
      logic [7:0]  points;
   } prc_cmd_s;

   typedef struct packed {
      logic [15:0] addr;
      logic [15:0] data;
   } prc_din_s;

   typedef struct packed {
      logic        req;
      logic        we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } prc_mem_s;

   typedef struct packed {
      logic [15:0] data;
      logic        last;
   } prc_rsp_s;

endpackage

// *** rtl/prc_cmd_handler.sv ***
`timescale 1ns/1ns
`include "prc_map.svh"

// Function
// [RL1] code 01 reads consecutive words from the head device back to requester
// [RL2] requester doubles point count for 32-bit counter batch reads
// [RL3] odd point count on 32-bit counter batch read: skip read, error 57H
// [RL4] code 03 writes supplied words into consecutive devices from head device
// [RL5] requester doubles point count for 32-bit counter batch writes
// [RL6] odd point count on 32-bit counter batch write: skip write, error 57H
// [RL7] code 05 writes each addressed word; refused for 32-bit counters
// [RL8] command 13H forces controller running regardless of local switch
// [RL9] command 14H forces controller stopped regardless of local switch
// [RL10] run and stop requests from all sources apply in execution order
// [RL11] power cycle clears remote forcing; local switch governs again
// [RL12] command 15H returns the controller model code
// [RL13] requester identifies the model only from the model code
// [RL14] command 16H echoes received loopback data unchanged
// [RL15] binary loopback payload at most 254 bytes of any value
// [RL16] ascii loopback payload at most 254 hex digit characters
// [RL17] requester sends loopback head part first, echo keeps order
// [RL18] requester uses head numbers multiple of 16 for bit devices
// [RL19] requester never mixes 16-bit and 32-bit counters in one request
// [RL20] every accepted request gets a response with end or error code
module prc_cmd_handler import prc_pkg::*; #(
   parameter logic [7:0] MODEL_CODE  = 8'hA5,  // arbitrary value
   parameter logic [7:0] ERR_BAD_CMD = 8'h50,
   parameter logic [7:0] ERR_BAD_LEN = 8'h51
) (
   input  wire logic     core_clk,
   input  wire logic     rst_b,
   input  wire logic     ce,
   input  wire prc_cmd_s cmd,
   input  wire logic     cmd_valid,
   output logic          cmd_ready,
   input  wire prc_din_s din,
   input  wire logic     din_valid,
   output logic          din_ready,
   output prc_mem_s      mem,
   input  wire logic     mem_ack,
   input  wire logic [15:0] mem_rdata,
   output prc_rsp_s      rsp,
   output logic          rsp_valid,
   input  wire logic     rsp_ready,
   input  wire logic     run_switch_pin,
   input  wire logic     pwr_ok_pin,
   input  wire logic     link_run,
   input  wire logic     link_stop,
   output logic          plc_run,
   output logic          remote_forced
);

   typedef struct packed {
      prc_state_e  state;
      logic [7:0]  code;
      logic        c32;
      logic [7:0]  err;
      logic [15:0] head;
      logic [8:0]  idx;
      logic [8:0]  total;
      logic        rsp_valid;
      prc_rsp_s    rsp;
      prc_mem_s    mem;
      logic        force_on;
      logic        force_run;
      logic        run;
   } prc_st_s;

   localparam prc_st_s ST_RST = '{
      state:     ST_IDLE,
      code:      8'h00,
      c32:       1'b0,
      err:       `PRC_END_OK,
      head:      `PRC_WORD_RST,
      idx:       `PRC_IDX_RST,
      total:     `PRC_IDX_RST,
      rsp_valid: 1'b0,
      rsp:       '0,
      mem:       '0,
      force_on:  1'b0,
      force_run: 1'b0,
      run:       1'b0
   };

   prc_st_s    r;
   prc_st_s    n;
   logic [1:0] pin_s;
   logic       switch_s;
   logic       pwr_ok_s;
   logic [8:0] idx_inc;
   logic [8:0] idx_inc2;
   logic       lb_we;
   logic [7:0] lb_waddr;
   logic [7:0] lb_wdata;
   logic [7:0] lb_raddr;
   logic [7:0] lb_rdata;

   prc_sync2 #(
      .W (2)
   ) u_sync (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .ce       (ce),
      .d_in     ({run_switch_pin, pwr_ok_pin}),
      .q_out    (pin_s)
   );

   assign switch_s = pin_s[1];
   assign pwr_ok_s = pin_s[0];

   prc_lb_buf #(
      .DW (8),
      .AW (8)
   ) u_lb_buf (
      .core_clk (core_clk),
      .ce       (ce),
      .we       (lb_we),
      .waddr    (lb_waddr),
      .wdata    (lb_wdata),
      .raddr    (lb_raddr),
      .rdata    (lb_rdata)
   );

   // end code decided at acceptance so a refused access never touches memory
   function automatic logic [7:0] check_err(input prc_cmd_s c);
      logic [7:0] e;
      e = `PRC_END_OK;
      case (c.code)
         // [RL3] [RL6] odd counter count
         `PRC_CMD_BATCH_RD, `PRC_CMD_BATCH_WR: begin
            if (c.c32 && c.points[0]) begin
               e = `PRC_ERR_ODD_C32;
            end
         end
         // [RL7] no 32-bit counters
         `PRC_CMD_RAND_WR: begin
            if (c.c32) begin
               e = `PRC_ERR_ODD_C32;
            end
         end
         `PRC_CMD_RUN, `PRC_CMD_STOP, `PRC_CMD_MODEL: begin
            e = `PRC_END_OK;
         end
         `PRC_CMD_LOOP: begin
            if (c.points > `PRC_LB_MAX) begin
               e = ERR_BAD_LEN;
            end
         end
         default: begin
            e = ERR_BAD_CMD;
         end
      endcase
      return e;
   endfunction

   // whether data beats follow the header
   function automatic logic has_data(input prc_st_s s);
      logic d;
      d = 1'b0;
      if (s.err == `PRC_END_OK) begin
         case (s.code)
            `PRC_CMD_BATCH_RD, `PRC_CMD_LOOP: d = (s.total != `PRC_IDX_RST);
            `PRC_CMD_MODEL:                   d = 1'b1;
            default:                          d = 1'b0;
         endcase
      end
      return d;
   endfunction

   // [RL20] header beat carries end code
   function automatic prc_st_s enter_hdr(input prc_st_s s);
      prc_st_s t;
      t                                                = s;
      t.state                                          = ST_HDR;
      t.rsp_valid                                      = 1'b1;
      t.rsp.data[`PRC_HDR_CMD_MSB:`PRC_HDR_CMD_LSB]    = s.code;
      t.rsp.data[`PRC_HDR_END_MSB:`PRC_HDR_END_LSB]    = s.err;
      t.rsp.last                                       = !has_data(s);
      return t;
   endfunction

   assign idx_inc  = r.idx + 9'h001;
   assign idx_inc2 = r.idx + 9'h002;

   always_comb begin
      n        = r;
      lb_we    = 1'b0;
      lb_waddr = r.idx[7:0];
      lb_wdata = din.data[7:0];
      lb_raddr = (r.state == ST_HDR) ? 8'h00 : idx_inc[7:0];

      // [RL10] link requests first
      if (link_run) begin
         n.force_on  = 1'b1;
         n.force_run = 1'b1;
      end else if (link_stop) begin
         n.force_on  = 1'b1;
         n.force_run = 1'b0;
      end

      case (r.state)
         ST_IDLE: begin
            if (cmd_valid) begin
               n.code  = cmd.code;
               n.c32   = cmd.c32;
               n.head  = cmd.head;
               n.idx   = `PRC_IDX_RST;
               n.total = {1'b0, cmd.points};
               n.err   = check_err(cmd);
               // [RL8] [RL9] own command executes after link request
               if (cmd.code == `PRC_CMD_RUN) begin
                  n.force_on  = 1'b1;
                  n.force_run = 1'b1;
               end else if (cmd.code == `PRC_CMD_STOP) begin
                  n.force_on  = 1'b1;
                  n.force_run = 1'b0;
               end
               if (n.err == `PRC_END_OK && n.total != `PRC_IDX_RST &&
                   (cmd.code == `PRC_CMD_BATCH_WR || cmd.code == `PRC_CMD_RAND_WR)) begin
                  n.state = ST_DIN;
               end else if (n.err == `PRC_END_OK && n.total != `PRC_IDX_RST &&
                            cmd.code == `PRC_CMD_LOOP) begin
                  n.state = ST_LBRX;
               end else begin
                  n = enter_hdr(n);
               end
            end
         end
         ST_DIN: begin
            if (din_valid) begin
               n.mem.req   = 1'b1;
               n.mem.we    = 1'b1;
               // [RL7] each entry carries its own address
               // [RL4] consecutive from head
               n.mem.addr  = (r.code == `PRC_CMD_RAND_WR) ? din.addr : r.head + {7'h00, r.idx};
               n.mem.wdata = din.data;
               n.state     = ST_MEMWR;
            end
         end
         ST_MEMWR: begin
            if (mem_ack) begin
               n.mem.req = 1'b0;
               n.mem.we  = 1'b0;
               n.idx     = idx_inc;
               if (idx_inc == r.total) begin
                  n = enter_hdr(n);
               end else begin
                  n.state = ST_DIN;
               end
            end
         end
         ST_HDR: begin
            if (rsp_ready) begin
               n.rsp_valid = 1'b0;
               if (r.rsp.last) begin
                  n.state = ST_IDLE;
               end else begin
                  case (r.code)
                     // [RL1] first read from head device
                     `PRC_CMD_BATCH_RD: begin
                        n.mem.req  = 1'b1;
                        n.mem.we   = 1'b0;
                        n.mem.addr = r.head + {7'h00, r.idx};
                        n.state    = ST_MEMRD;
                     end
                     // [RL12] model code beat
                     `PRC_CMD_MODEL: begin
                        n.rsp_valid = 1'b1;
                        n.rsp.data  = {8'h00, MODEL_CODE};
                        n.rsp.last  = 1'b1;
                        n.state     = ST_SEND;
                     end
                     `PRC_CMD_LOOP: begin
                        n.rsp_valid = 1'b1;
                        n.rsp.data  = {8'h00, lb_rdata};
                        n.rsp.last  = (r.total == 9'h001);
                        n.state     = ST_LBTX;
                     end
                     default: begin
                        n.state = ST_IDLE;
                     end
                  endcase
               end
            end
         end
         ST_MEMRD: begin
            if (mem_ack) begin
               n.mem.req   = 1'b0;
               n.rsp_valid = 1'b1;
               n.rsp.data  = mem_rdata;
               n.rsp.last  = (idx_inc == r.total);
               n.state     = ST_SEND;
            end
         end
         ST_SEND: begin
            if (rsp_ready) begin
               n.rsp_valid = 1'b0;
               if (r.rsp.last) begin
                  n.state = ST_IDLE;
               end else begin
                  // [RL1] next consecutive word
                  n.idx      = idx_inc;
                  n.mem.req  = 1'b1;
                  n.mem.addr = r.head + {7'h00, idx_inc};
                  n.state    = ST_MEMRD;
               end
            end
         end
         ST_LBRX: begin
            if (din_valid) begin
               // [RL14] store bytes in arrival order
               lb_we = 1'b1;
               n.idx = idx_inc;
               if (idx_inc == r.total) begin
                  n.idx = `PRC_IDX_RST;
                  n     = enter_hdr(n);
               end
            end
         end
         ST_LBTX: begin
            if (rsp_ready) begin
               if (r.rsp.last) begin
                  n.rsp_valid = 1'b0;
                  n.state     = ST_IDLE;
               end else begin
                  // [RL14] echo unchanged, same order
                  n.idx      = idx_inc;
                  n.rsp.data = {8'h00, lb_rdata};
                  n.rsp.last = (idx_inc2 == r.total);
               end
            end
         end
         default: begin
            n = ST_RST;
         end
      endcase

      // [RL11] power loss drops forcing
      if (!pwr_ok_s) begin
         n.force_on  = 1'b0;
         n.force_run = 1'b0;
      end
      // [RL8] [RL9] forcing overrides switch
      n.run = n.force_on ? n.force_run : switch_s;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         r <= ST_RST;
      end else if (ce) begin
         r <= n;
      end
   end

   assign cmd_ready     = (r.state == ST_IDLE);
   assign din_ready     = (r.state == ST_DIN) || (r.state == ST_LBRX);
   assign mem           = r.mem;
   assign rsp           = r.rsp;
   assign rsp_valid     = r.rsp_valid;
   assign plc_run       = r.run;
   assign remote_forced = r.force_on;

endmodule

// *** rtl/prc_lb_buf.sv ***
`timescale 1ns/1ns

module prc_lb_buf import prc_pkg::*; #(
   parameter int DW = 8,
   parameter int AW = 8
) (
   input  wire logic          core_clk,
   input  wire logic          ce,
   input  wire logic          we,
   input  wire logic [AW-1:0] waddr,
   input  wire logic [DW-1:0] wdata,
   input  wire logic [AW-1:0] raddr,
   output logic      [DW-1:0] rdata
);

   // payload store; contents need no reset, length is tracked outside
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge core_clk) begin
      if (ce && we) begin
         mem[waddr] <= wdata;
      end
   end

   // asynchronous read lets the sender preload the next byte in one cycle
   assign rdata = mem[raddr];

endmodule

// *** rtl/prc_sync2.sv ***
`timescale 1ns/1ns
`include "prc_map.svh"

module prc_sync2 import prc_pkg::*; #(
   parameter int W = 2
) (
   input  wire logic         core_clk,
   input  wire logic         rst_b,
   input  wire logic         ce,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } prc_sync_s;

   prc_sync_s r;
   prc_sync_s n;

   // first stage feeds only the second
   always_comb begin
      n    = r;
      n.s1 = d_in;
      n.s2 = r.s1;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         r <= {(2*W){`PRC_SYNC_RST}};
      end else if (ce) begin
         r <= n;
      end
   end

   assign q_out = r.s2;

endmodule
